// File: sild_checker.sv
// Port checker for the display driver top
`timescale 1ns/10ps
`default_nettype none
module sild_checker (
  // Clocks and reset
  input wire logic                 core_clk,
  input wire logic                 rst_b,
  input wire logic                 shift_clk,
  // Link and controls
  input wire logic                 ser_data,
  input wire logic                 latch_en,
  input wire logic                 out_gate_b,
  input wire logic                 ser_out,
  input wire logic                 shift_full,
  input wire logic                 snap_stall,
  // Display
  input wire sild_pkg::sild_word_t driver_outputs
);
  import sild_pkg::*;
  logic [3:0] n_q;
  logic [4:0] quiet_q;
  // Stages hold unknowns until twelve bits went in
  always_ff @(posedge shift_clk or negedge rst_b)
    if (!rst_b) n_q <= 4'h0;
    else if (n_q != 4'hC) n_q <= n_q + 4'h1;
  // Quiet: transparent, ungated, no shifting, snapshot path drained and not full.
  // 24 cycles cover a full drain of the snapshot buffer plus control lag.
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) quiet_q <= 5'h00;
    else if (shift_clk || !latch_en || out_gate_b) quiet_q <= 5'h00;
    else if (snap_stall || shift_full) quiet_q <= 5'h00;
    else if (quiet_q != 5'h18) quiet_q <= quiet_q + 5'h01;
  shift_a: assert property (@(posedge shift_clk) disable iff (!rst_b)
    n_q == 4'hC |-> ser_out == $past(ser_data, 12)) else $error("ser_out lost a bit");
  still_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    n_q == 4'hC && !shift_clk && !$past(shift_clk) |-> $stable(ser_out))
    else $error("ser_out moved without shift edge");
  reset_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(rst_b) |-> driver_outputs == 12'h000) else $error("outputs not blank at reset");
  blank_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    out_gate_b [*8] ##1 out_gate_b |-> driver_outputs == 12'h000) else $error("gate ignored");
  blank_soon_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(out_gate_b) |-> ##[1:9] driver_outputs == 12'h000) else $error("blanking late");
  follow_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    n_q == 4'hC && quiet_q == 5'h18 |-> driver_outputs[11] == ser_out)
    else $error("channel 12 not stage 12");
  steady_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    quiet_q == 5'h18 ##1 quiet_q == 5'h18 |-> $stable(driver_outputs)) else $error("glitch");
  hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!latch_en && !out_gate_b) [*8] ##1 (!latch_en && !out_gate_b) [*4] |=>
    $stable(driver_outputs)) else $error("latches not holding");
  cover property (@(posedge core_clk) quiet_q == 5'h18);
  cover property (@(posedge core_clk) (!latch_en && !out_gate_b) [*8]);
  cover property (@(posedge core_clk) $rose(out_gate_b));
  cover property (@(posedge core_clk) $fell(shift_full));
endmodule : sild_checker
bind sild_top sild_checker sild_checker_inst (.core_clk, .rst_b, .shift_clk, .ser_data,
  .latch_en, .out_gate_b, .ser_out, .shift_full, .snap_stall, .driver_outputs);
`default_nettype wire

// File: sild_fifo.sv
// Dual-clock snapshot FIFO with gray-coded pointers and registered read data
`timescale 1ns/10ps
`default_nettype none
module sild_fifo #(
  parameter int W = 12,
  parameter int D = 16
) (
  // Write side
  input  wire logic         wr_clk,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_ready,
  output logic              wr_full,
  // Read side
  input  wire logic         rd_clk,
  output logic              rd_valid,
  output logic [W-1:0]      rd_data,
  input  wire logic         rd_ready,
  // Reset
  input  wire logic         rst_b
);
  import sild_pkg::*;

  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wbin_q, wgray_q, rbin_q, rgray_q;
  logic [AW:0]  rg_s1_q, rg_s2_q, wg_s1_q, wg_s2_q;
  logic [AW:0]  wbin_d, wgray_d, rbin_d, rgray_d;
  logic         full_q, empty_q, rvalid_q;
  logic [W-1:0] rdata_q;
  logic         push, pop;

  assign push    = wr_valid & ~full_q;
  assign wbin_d  = wbin_q + {{AW{1'b0}}, push};
  assign wgray_d = wbin_d ^ (wbin_d >> 1);
  assign wr_ready = ~full_q;
  assign wr_full  = full_q;

  always_ff @(posedge wr_clk or negedge rst_b) begin
    if (!rst_b) begin
      wbin_q  <= '0;
      wgray_q <= '0;
      full_q  <= 1'b0;
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= wgray_d;
      full_q  <= (wgray_d == {~rg_s2_q[AW:AW-1], rg_s2_q[AW-2:0]});
    end
  end

  always_ff @(posedge wr_clk or negedge rst_b) begin
    if (!rst_b) begin
      rg_s1_q <= '0;
      rg_s2_q <= '0;
    end else begin
      rg_s1_q <= rgray_q;
      rg_s2_q <= rg_s1_q;
    end
  end

  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem_q[wbin_q[AW-1:0]] <= wr_data;
    end
  end

  // Pop when the output register is free or being taken
  assign pop     = ~empty_q & (~rvalid_q | rd_ready);
  assign rbin_d  = rbin_q + {{AW{1'b0}}, pop};
  assign rgray_d = rbin_d ^ (rbin_d >> 1);

  always_ff @(posedge rd_clk or negedge rst_b) begin
    if (!rst_b) begin
      wg_s1_q <= '0;
      wg_s2_q <= '0;
    end else begin
      wg_s1_q <= wgray_q;
      wg_s2_q <= wg_s1_q;
    end
  end

  always_ff @(posedge rd_clk or negedge rst_b) begin
    if (!rst_b) begin
      rbin_q   <= '0;
      rgray_q  <= '0;
      empty_q  <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end else begin
      rbin_q   <= rbin_d;
      rgray_q  <= rgray_d;
      empty_q  <= (rgray_d == wg_s2_q);
      rvalid_q <= pop | (rvalid_q & ~rd_ready);
      if (pop) begin
        rdata_q <= mem_q[rbin_q[AW-1:0]];
      end
    end
  end

  assign rd_valid = rvalid_q;
  assign rd_data  = rdata_q;

endmodule : sild_fifo
`default_nettype wire

// File: sild_host.sv
// Host model: shift clock and serial data for one device
`timescale 1ns/10ps
`default_nettype none
module sild_host (
  // Link to device
  output var logic shift_clk,
  output var logic ser_data
);
  initial begin
    shift_clk = 1'b0;
    ser_data  = 1'b1;
  end
  // Twelve bits per device, first bit lands on channel 12
  task automatic send(input logic [11:0] w);
    #7;
    for (int i = 11; i >= 0; i--) begin
      ser_data = w[i];
      #40 shift_clk = 1'b1;
      #40 shift_clk = 1'b0;
    end
    // Released data pin floats high; clock stands low between frames
    #40 ser_data = 1'b1;
  endtask : send
endmodule : sild_host
`default_nettype wire

// File: sild_pkg.sv
// Constants and types shared by the serial-in latched display driver
// Summary of operation
// - Twelve shift stages, latches, gated outputs
// - Shift only on rising shift clock
// - Stage n takes n-1; first takes data
// - Latch control high: latches follow stages
// - Latch control low: latches hold values
// - Gate low: outputs show latches in order
// - Output is latch AND inverted gate
// - Serial output always shows twelfth stage
// - Undriven inputs read as high; the code has no pull-ups, only the control pipeline resets high
package sild_pkg;

  localparam int SILD_CHANNELS = 12;
  localparam int SILD_FIFO_DEPTH = 16;
  localparam int SILD_SYNC_STAGES = 2;
  // Extra control delay so latch control lines up with the snapshot path
  localparam int SILD_CTL_ALIGN = 4;

  typedef logic [SILD_CHANNELS-1:0] sild_word_t;

  typedef struct packed {
    logic latch_en;
    logic out_gate_b;
  } sild_ctl_t;

  localparam sild_word_t SILD_WORD_RST = 12'h000;
  // Idle level of a floating control pin is high
  localparam sild_ctl_t SILD_CTL_RST = 2'h3;

endpackage : sild_pkg

// File: sild_top.sv
// Serial-in latched display driver: shift stages, storage latches, gated outputs
`timescale 1ns/10ps
`default_nettype none
module sild_top #(
  parameter int N     = sild_pkg::SILD_CHANNELS,
  parameter int DEPTH = sild_pkg::SILD_FIFO_DEPTH,
  parameter int ALIGN = sild_pkg::SILD_CTL_ALIGN
) (
  // Core clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  // Link from host, on the host shift clock
  input  wire logic             shift_clk,
  input  wire logic             ser_data,
  // Control pins from host, asynchronous to core_clk
  input  wire logic             latch_en,
  input  wire logic             out_gate_b,
  // Link back to host
  output logic                  ser_out,
  output logic                  shift_full,
  // Snapshot drain control, core domain
  input  wire logic             snap_stall,
  // Display
  output sild_pkg::sild_word_t  driver_outputs
);
  import sild_pkg::*;

  logic [N-1:0] shift_stages_q;
  logic [N-1:0] shift_stages_d;
  logic         snap_valid;
  sild_word_t   snap_data;
  logic         snap_ready;
  sild_ctl_t    ctl_pin;
  sild_ctl_t    ctl_sync_q [SILD_SYNC_STAGES];
  sild_ctl_t    ctl_dly_q  [ALIGN];
  sild_ctl_t    ctl_use;
  sild_word_t   mirror_q;
  sild_word_t   storage_latches_q;
  sild_word_t   driver_outputs_q;

  // Link domain: no reset, the host preloads known bits before latching
  assign shift_stages_d = {shift_stages_q[N-2:0], ser_data};

  always_ff @(posedge shift_clk) begin
    shift_stages_q <= shift_stages_d;
  end

  // Cascade tap comes straight from the last stage
  assign ser_out = shift_stages_q[N-1];

  // Every shift edge while the FIFO is not full pushes the new stage contents towards the core
  sild_fifo #(
    .W (N),
    .D (DEPTH)
  ) u_snap_fifo (
    .wr_clk   (shift_clk),
    .wr_valid (1'b1),
    .wr_data  (shift_stages_d),
    .wr_ready (),
    .wr_full  (shift_full),
    .rd_clk   (core_clk),
    .rd_valid (snap_valid),
    .rd_data  (snap_data),
    .rd_ready (snap_ready),
    .rst_b    (rst_b)
  );

  assign snap_ready = ~snap_stall;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mirror_q <= SILD_WORD_RST;
    end else if (snap_valid && snap_ready) begin
      mirror_q <= snap_data;
    end
  end

  // Control pins: two-stage synchroniser, then delay to match the snapshot path
  assign ctl_pin = '{latch_en: latch_en, out_gate_b: out_gate_b};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < SILD_SYNC_STAGES; i++) begin
        ctl_sync_q[i] <= SILD_CTL_RST;
      end
    end else begin
      ctl_sync_q[0] <= ctl_pin;
      for (int i = 1; i < SILD_SYNC_STAGES; i++) begin
        ctl_sync_q[i] <= ctl_sync_q[i-1];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < ALIGN; i++) begin
        ctl_dly_q[i] <= SILD_CTL_RST;
      end
    end else begin
      ctl_dly_q[0] <= ctl_sync_q[SILD_SYNC_STAGES-1];
      for (int i = 1; i < ALIGN; i++) begin
        ctl_dly_q[i] <= ctl_dly_q[i-1];
      end
    end
  end

  assign ctl_use = ctl_dly_q[ALIGN-1];

  // Storage latches follow while enabled, hold otherwise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      storage_latches_q <= SILD_WORD_RST;
    end else if (ctl_use.latch_en) begin
      storage_latches_q <= mirror_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      driver_outputs_q <= SILD_WORD_RST;
    end else begin
      driver_outputs_q <= storage_latches_q & {N{~ctl_use.out_gate_b}};
    end
  end

  assign driver_outputs = driver_outputs_q;

endmodule : sild_top
`default_nettype wire

// File: tb.sv
// Self-checking bench for the display driver top
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sild_pkg::*;
  logic       core_clk = 1'b0, rst_b = 1'b0, latch_en = 1'b1, out_gate_b = 1'b1;
  logic       snap_stall = 1'b0, ser_out, shift_full;
  wire logic  shift_clk, ser_data;
  sild_word_t driver_outputs;
  int         fail_count = 0, compares = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  sild_host host_inst (.shift_clk, .ser_data);
  sild_top sild_top_inst (.core_clk, .rst_b, .shift_clk, .ser_data, .latch_en, .out_gate_b,
    .ser_out, .shift_full, .snap_stall, .driver_outputs);
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step
  task automatic chk(input string s, input sild_word_t e, input sild_word_t g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic t_load;
    host_inst.send(12'hA5C);
    step(15);
    chk("ser_out", 12'h001, {11'h000, ser_out});
    out_gate_b = 1'b0;
    // Long enough for the checker's quiet window to compare channel 12
    step(30);
    chk("outputs", 12'hA5C, driver_outputs);
  endtask : t_load
  task automatic t_hold;
    latch_en = 1'b0;
    step(4);
    host_inst.send(12'h3C1);
    step(15);
    chk("outputs", 12'hA5C, driver_outputs);
    chk("ser_out", 12'h000, {11'h000, ser_out});
  endtask : t_hold
  task automatic t_blank;
    out_gate_b = 1'b1;
    step(10);
    chk("outputs", 12'h000, driver_outputs);
    out_gate_b = 1'b0;
    latch_en = 1'b1;
    step(12);
    chk("outputs", 12'h3C1, driver_outputs);
  endtask : t_blank
  task automatic t_fill;
    snap_stall = 1'b1;
    host_inst.send(12'h111);
    host_inst.send(12'h222);
    chk("full", 12'h001, {11'h000, shift_full});
    snap_stall = 1'b0;
    step(30);
    // Full lives on the shift clock: only new shift edges can clear it
    host_inst.send(12'h4B7);
    chk("full", 12'h000, {11'h000, shift_full});
    step(30);
    chk("outputs", 12'h4B7, driver_outputs);
  endtask : t_fill
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    step(10);
    rst_b = 1'b1;
    step(3);
    t_load();
    t_hold();
    t_blank();
    t_fill();
    summarize();
  end
endmodule : tb
`default_nettype wire
